// file: pkg/apc_pkg.sv
// Package for the analog pin share configuration block
package apc_pkg;
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CMP2_CONFIG = 8'h9b;
	localparam logic [7:0] IDX_OPAMP_MODE  = 8'h9f;
	localparam logic [7:0] IDX_PORT4_ISO   = 8'hae;
	localparam logic [7:0] IDX_PORT0_ISO   = 8'haf;
	localparam logic [7:0] IDX_ADC_MODE    = 8'hb1;
	localparam logic [7:0] IDX_PORT0_DATA  = 8'hc0;
	localparam logic [7:0] IDX_PORT4_DATA  = 8'hc1;
	localparam int ADDR_W = 10;
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// Writable masks
	localparam logic [7:0] MASK_CMP2   = 8'h3f;
	localparam logic [7:0] MASK_OPAMP  = 8'h03;
	localparam logic [7:0] MASK_P4ISO  = 8'h7f;
	localparam logic [7:0] MASK_P0ISO  = 8'h0f;
	// Field positions
	localparam int CMP2_NEG_SRC_BIT   = 2;
	localparam int OPAMP_EN_BIT       = 0;
	localparam int OPAMP_POS_SRC_BIT  = 1;
	localparam int ADC_EN_BIT         = 7;
	localparam int GLOBAL_CH_EN_BIT   = 4;
	localparam int CH_SEL_LSB         = 0;
	localparam int P05_ISO_BIT        = 3;
	// Port-0 analog pins P0.2..P0.5 map to port bits 2..5
	localparam int P0_ANALOG_LSB      = 2;
	localparam int P0_PINS            = 6;
	localparam int P4_ANALOG_PINS     = 7;
	localparam int P4_PINS            = 8;
	localparam logic [2:0] CH_OPAMP_OUT = 3'h7;
	// Level shown on an isolated pin's data read
	localparam logic ISO_READ_LEVEL   = 1'b0;

	typedef struct packed {
		logic [7:0] cmp2;
		logic [7:0] opamp;
		logic [7:0] p4iso;
		logic [7:0] p0iso;
		logic [7:0] adc;
	} apc_regs_s;

	typedef struct packed {
		logic       adc_en;
		logic       adc_sel_opamp;
		logic [6:0] adc_pin_sel;
		logic       opamp_out_pin;
		logic       opamp_neg_pin;
		logic       opamp_pos_pin;
		logic       opamp_pos_gnd;
		logic       cmp2_neg_pin;
		logic       cmp2_neg_from_cmp0;
	} apc_route_s;
endpackage

// file: design/apc_pin_share.sv
// Analog pin share configuration for port 0 and port 4
// What this block does
// - Port-0 isolation bits make P0.2..P0.5 analog
// - Set bit isolates digital path, clear allows both
// - Neg-source zero: P0.5 feeds comparator 2 negative
// - Neg-source one: P0.5 digital, cmp2 neg to cmp0
// - Port-4 isolation bits make pins pure analog
// - At most one port-4 pin routed to ADC
// - Global channel enable gates pin to ADC
// - Codes 0..6 pick inputs, 7 picks op-amp
// - Op-amp off: P4.0..P4.2 digital or ADC
// - Op-amp on, ADC off: P4.0..P4.2 op-amp pins
// - Plus positive-source set: P4.2 stays digital
// - Positive-source one grounds op-amp positive input
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module apc_pin_share (
	input  wire logic                    clk_i,        // 125 MHz clock
	input  wire logic                    rst_i,        // Sync reset, high
	input  wire logic                    cyc_i,        // Wishbone cycle
	input  wire logic                    stb_i,        // Wishbone strobe
	input  wire logic                    we_i,         // Write enable
	input  wire logic [apc_pkg::ADDR_W-1:0] adr_i,     // Byte address
	input  wire logic [3:0]              sel_i,        // Byte selects
	input  wire logic [31:0]             dat_i,        // Write data
	output logic      [31:0]             dat_o,        // Read data
	output logic                         ack_o,        // Acknowledge
	output logic                         err_o,        // Unmapped address
	input  wire logic [5:0]              p0_pin_i,     // Port 0 pad levels
	input  wire logic [7:0]              p4_pin_i,     // Port 4 pad levels
	output logic      [3:0]              p0_dig_iso_o, // P0.2..P0.5 cut off
	output logic      [6:0]              p4_dig_iso_o, // P4.0..P4.6 cut off
	output var apc_pkg::apc_route_s      route_o       // Analog switches
);
	apc_pkg::apc_regs_s regs;
	apc_pkg::apc_route_s next_route;
	logic [5:0] p0_meta, p0_sync;
	logic [7:0] p4_meta, p4_sync;
	logic [3:0] next_p0_iso;
	logic [6:0] next_p4_iso;

	// Bus decode
	wire        req      = cyc_i & stb_i & ~ack_o & ~err_o;
	wire        wr_lane  = we_i & sel_i[0];
	wire [7:0]  idx      = 8'(adr_i[apc_pkg::ADDR_W-1:2]);
	wire        hit_cmp2 = idx == apc_pkg::IDX_CMP2_CONFIG;
	wire        hit_opm  = idx == apc_pkg::IDX_OPAMP_MODE;
	wire        hit_p4i  = idx == apc_pkg::IDX_PORT4_ISO;
	wire        hit_p0i  = idx == apc_pkg::IDX_PORT0_ISO;
	wire        hit_adc  = idx == apc_pkg::IDX_ADC_MODE;
	wire        hit_p0d  = idx == apc_pkg::IDX_PORT0_DATA;
	wire        hit_p4d  = idx == apc_pkg::IDX_PORT4_DATA;
	wire        mapped   = hit_cmp2 | hit_opm | hit_p4i | hit_p0i
		| hit_adc | hit_p0d | hit_p4d;
	wire [7:0]  wbyte    = dat_i[7:0];

	// Decoded configuration fields
	wire        neg_src  = regs.cmp2[apc_pkg::CMP2_NEG_SRC_BIT];
	wire        op_en    = regs.opamp[apc_pkg::OPAMP_EN_BIT];
	wire        op_psw   = regs.opamp[apc_pkg::OPAMP_POS_SRC_BIT];
	wire        adc_on   = regs.adc[apc_pkg::ADC_EN_BIT];
	wire        gch_en   = regs.adc[apc_pkg::GLOBAL_CH_EN_BIT];
	wire [2:0]  ch_sel   = regs.adc[apc_pkg::CH_SEL_LSB +: 3];
	wire        op_pins  = op_en & ~adc_on;
	wire        ch_op    = ch_sel == apc_pkg::CH_OPAMP_OUT;
	// One-hot pin decode: a single code can light only one pin
	wire [7:0]  ch_hot   = 8'h01 << ch_sel;
	wire [6:0]  adc_pins = gch_en ? ch_hot[6:0] : 7'h00;

	// Read mux: write-only isolation registers read as zero
	// Uses the forced P0.5 cut-off too, so a comparator pin never leaks
	wire [7:0]  p0_view  = {2'b00, (p0_sync[5:2] & ~next_p0_iso)
		| ({4{apc_pkg::ISO_READ_LEVEL}} & next_p0_iso),
		p0_sync[1:0]};
	wire [7:0]  p4_view  = {p4_sync[7], (p4_sync[6:0] & ~regs.p4iso[6:0])
		| ({7{apc_pkg::ISO_READ_LEVEL}} & regs.p4iso[6:0])};
	wire [7:0]  rd_byte  = hit_cmp2 ? regs.cmp2
		: hit_opm ? regs.opamp
		: hit_adc ? regs.adc
		: hit_p0d ? p0_view
		: hit_p4d ? p4_view
		: 8'h00;

	// Isolation: the register bit, plus P0.5 while it is cmp2's input
	always_comb begin
		next_p0_iso = regs.p0iso[3:0];
		next_p4_iso = regs.p4iso[6:0];
		next_route  = '0;
		next_route.adc_en        = adc_on;
		next_route.adc_pin_sel   = ch_op ? 7'h00 : adc_pins;
		next_route.adc_sel_opamp = gch_en & ch_op;
		next_route.opamp_out_pin = op_pins;
		next_route.opamp_neg_pin = op_pins;
		next_route.opamp_pos_pin = op_pins & ~op_psw;
		next_route.opamp_pos_gnd = op_en & op_psw;
		next_route.cmp2_neg_pin  = ~neg_src;
		next_route.cmp2_neg_from_cmp0 = neg_src;
		if (!neg_src) begin
			next_p0_iso[apc_pkg::P05_ISO_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			regs <= '0;
		end else if (req && wr_lane) begin
			if (hit_cmp2) regs.cmp2  <= wbyte & apc_pkg::MASK_CMP2;
			if (hit_opm)  regs.opamp <= wbyte & apc_pkg::MASK_OPAMP;
			if (hit_p4i)  regs.p4iso <= wbyte & apc_pkg::MASK_P4ISO;
			if (hit_p0i)  regs.p0iso <= wbyte & apc_pkg::MASK_P0ISO;
			if (hit_adc)  regs.adc   <= wbyte;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req & mapped;
			err_o <= req & ~mapped;
			dat_o <= {24'h00_0000, (req & ~we_i) ? rd_byte : 8'h00};
		end
	end

	// Pads are asynchronous to the core clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p0_meta <= '0;
			p0_sync <= '0;
			p4_meta <= '0;
			p4_sync <= '0;
		end else begin
			p0_meta <= p0_pin_i;
			p0_sync <= p0_meta;
			p4_meta <= p4_pin_i;
			p4_sync <= p4_meta;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p0_dig_iso_o <= '0;
			p4_dig_iso_o <= '0;
			route_o      <= '0;
		end else begin
			p0_dig_iso_o <= next_p0_iso;
			p4_dig_iso_o <= next_p4_iso;
			route_o      <= next_route;
		end
	end

	chk_adc_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
		$countones(route_o.adc_pin_sel) <= 1)
		else $error("more than one port-4 pin on the ADC");
	chk_gch_gates: assert property (@(posedge clk_i) disable iff (rst_i)
		!gch_en |=> route_o.adc_pin_sel == 7'h00)
		else $error("pin routed to ADC with channels disabled");
	chk_chan_decode: assert property (@(posedge clk_i) disable iff (rst_i)
		gch_en && ch_sel != apc_pkg::CH_OPAMP_OUT
		|=> route_o.adc_pin_sel[$past(ch_sel)])
		else $error("channel code did not select its pin");
	chk_opamp_code: assert property (@(posedge clk_i) disable iff (rst_i)
		gch_en && ch_sel == apc_pkg::CH_OPAMP_OUT
		|=> route_o.adc_sel_opamp && route_o.adc_pin_sel == 7'h00)
		else $error("code seven did not pick op-amp output");
	chk_p0_iso: assert property (@(posedge clk_i) disable iff (rst_i)
		req && wr_lane && hit_p0i
		|=> ##1 p0_dig_iso_o[2:0] == $past(wbyte[2:0], 2))
		else $error("port-0 isolation not applied");
	chk_cmp2_neg: assert property (@(posedge clk_i) disable iff (rst_i)
		!neg_src |=> p0_dig_iso_o[3] && route_o.cmp2_neg_pin
		&& !route_o.cmp2_neg_from_cmp0)
		else $error("P0.5 not isolated for comparator 2");
	chk_cmp2_int: assert property (@(posedge clk_i) disable iff (rst_i)
		neg_src |=> route_o.cmp2_neg_from_cmp0 && !route_o.cmp2_neg_pin)
		else $error("comparator 2 internal tie missing");
	chk_p4_iso: assert property (@(posedge clk_i) disable iff (rst_i)
		req && wr_lane && hit_p4i
		|=> ##1 p4_dig_iso_o == $past(wbyte[6:0], 2))
		else $error("port-4 isolation not applied");
	chk_opamp_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		op_en && !adc_on && !op_psw
		|=> route_o.opamp_out_pin && route_o.opamp_pos_pin)
		else $error("op-amp pins not connected");
	chk_opamp_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!op_en |=> !route_o.opamp_out_pin && !route_o.opamp_neg_pin
		&& !route_o.opamp_pos_pin)
		else $error("op-amp pins driven while disabled");
	chk_pos_gnd: assert property (@(posedge clk_i) disable iff (rst_i)
		op_en && op_psw |=> route_o.opamp_pos_gnd
		&& !route_o.opamp_pos_pin)
		else $error("op-amp positive input not grounded");
	chk_iso_read: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_p4d && regs.p4iso[0]
		|=> dat_o[0] == apc_pkg::ISO_READ_LEVEL)
		else $error("isolated pin leaked into data read");

	// Bus handshake: one answer per request, never both kinds
	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o
		|=> !ack_o)
		else $error("acknowledge held longer than one cycle");

	chk_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> !(ack_o && err_o))
		else $error("acknowledge and error raised together");

	chk_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
		req && mapped
		|=> ack_o && !err_o)
		else $error("mapped request not acknowledged next cycle");

	chk_err_timing: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !mapped
		|=> err_o && !ack_o)
		else $error("unmapped request not refused next cycle");

	chk_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!req
		|=> !ack_o && !err_o)
		else $error("answer given without a request");

	chk_rdata_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> dat_o[31:8] == 24'h00_0000)
		else $error("upper read data lanes not zero");

	chk_rd_iso_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && (hit_p4i || hit_p0i)
		|=> dat_o == 32'h0000_0000)
		else $error("write-only isolation register read back");

	chk_wr_no_data: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i
		|=> dat_o == 32'h0000_0000)
		else $error("read data driven on a write");

	// Register file: only a taken, lane-0 write may change it
	chk_lane_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && !sel_i[0]
		|=> $stable(regs))
		else $error("write without lane 0 changed a register");

	chk_read_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i
		|=> $stable(regs))
		else $error("read changed a register");

	chk_data_idx_ro: assert property (@(posedge clk_i) disable iff (rst_i)
		req && (hit_p0d || hit_p4d)
		|=> $stable(regs))
		else $error("pad data index changed a register");

	chk_p0iso_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> regs.p0iso[7:4] == 4'h0)
		else $error("unused port-0 isolation bits set");

	chk_p4iso_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> regs.p4iso[7] == 1'b0)
		else $error("unused port-4 isolation bit set");

	chk_opamp_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> regs.opamp[7:2] == 6'h00)
		else $error("unused op-amp mode bits set");

	// Isolation outputs follow the stored bits one cycle later, except P0.5, which is forced while it is cmp2's input
	chk_p4_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|=> p4_dig_iso_o == $past(regs.p4iso[6:0]))
		else $error("port-4 cut-off does not follow its register");

	chk_p0_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		neg_src
		|=> p0_dig_iso_o == $past(regs.p0iso[3:0]))
		else $error("port-0 cut-off does not follow its register");

	chk_cmp2_excl: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|=> route_o.cmp2_neg_pin != route_o.cmp2_neg_from_cmp0)
		else $error("comparator 2 negative source not exclusive");

	// Op-amp pin routing
	chk_adc_blocks_op: assert property (@(posedge clk_i) disable iff (rst_i)
		adc_on
		|=> !route_o.opamp_out_pin && !route_o.opamp_pos_pin)
		else $error("op-amp pins routed while ADC enabled");

	chk_opamp_neg: assert property (@(posedge clk_i) disable iff (rst_i)
		op_en && !adc_on
		|=> route_o.opamp_neg_pin && route_o.opamp_out_pin)
		else $error("op-amp output or negative pin missing");

	chk_psw_frees: assert property (@(posedge clk_i) disable iff (rst_i)
		op_psw
		|=> !route_o.opamp_pos_pin)
		else $error("P4.2 held by op-amp with ground source");

	chk_gnd_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!op_psw
		|=> !route_o.opamp_pos_gnd)
		else $error("op-amp positive input grounded wrongly");

	// ADC channel routing
	chk_adc_en_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|=> route_o.adc_en == $past(adc_on))
		else $error("ADC enable not reported");

	chk_no_op_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		!gch_en
		|=> !route_o.adc_sel_opamp)
		else $error("op-amp output on ADC with channels disabled");

	chk_op_sel_nopin: assert property (@(posedge clk_i) disable iff (rst_i)
		route_o.adc_sel_opamp
		|-> route_o.adc_pin_sel == 7'h00)
		else $error("pin routed together with op-amp output");

	chk_one_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		gch_en && ch_sel != apc_pkg::CH_OPAMP_OUT
		|=> $countones(route_o.adc_pin_sel) == 1)
		else $error("enabled channel did not route exactly one pin");

	// Data reads never show an isolated pin's level
	chk_p4_view: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_p4d
		|=> (dat_o[6:0] & $past(regs.p4iso[6:0])) == 7'h00)
		else $error("isolated port-4 pin visible in read");

	chk_p0_view: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_p0d
		|=> (dat_o[5:2] & $past(next_p0_iso)) == 4'h0)
		else $error("isolated port-0 pin visible in read");
endmodule // apc_pin_share
`default_nettype wire

// file: dv/apc_pad_model.sv
// Pad and analog front-end model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module apc_pad_model (
	input  wire logic       clk_i,        // Bench clock
	input  wire logic [5:0] p0_lvl_i,     // Digital level on port 0
	input  wire logic [7:0] p4_lvl_i,     // Digital level on port 4
	input  wire logic [3:0] p0_dig_iso_i, // P0.2..P0.5 analog only
	input  wire logic [6:0] p4_dig_iso_i, // P4.0..P4.6 analog only
	output logic      [5:0] p0_pin_o,     // Port 0 pads
	output logic      [7:0] p4_pin_o      // Port 4 pads
);
	logic tog = 1'b0;
	// Analog pins sit near mid-rail, so their digital level is unreliable
	always_ff @(posedge clk_i) begin
		tog <= ~tog;
	end
	assign p0_pin_o = p0_lvl_i ^ ({p0_dig_iso_i, 2'b00} & {6{tog}});
	assign p4_pin_o = p4_lvl_i ^ ({1'b0, p4_dig_iso_i} & {8{tog}});
endmodule // apc_pad_model
`default_nettype wire

// file: dv/testbench.sv
// Register-level bench for the analog pin share block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, dat_o, rd;
	logic        ack_o, err_o, e;
	logic [5:0]  p0_lvl = 6'h00, p0_pin;
	logic [7:0]  p4_lvl = 8'h00, p4_pin;
	logic [3:0]  p0_dig_iso_o;
	logic [6:0]  p4_dig_iso_o;
	apc_pkg::apc_route_s route_o;
	int err_total = 0, n_checks = 0;
	always #4 clk_i = ~clk_i;
	apc_pin_share uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .err_o(err_o), .p0_pin_i(p0_pin), .p4_pin_i(p4_pin),
		.p0_dig_iso_o(p0_dig_iso_o), .p4_dig_iso_o(p4_dig_iso_o),
		.route_o(route_o));
	apc_pad_model pads (.clk_i(clk_i), .p0_lvl_i(p0_lvl), .p4_lvl_i(p4_lvl),
		.p0_dig_iso_i(p0_dig_iso_o), .p4_dig_iso_i(p4_dig_iso_o),
		.p0_pin_o(p0_pin), .p4_pin_o(p4_pin));
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic cycle; returns after one idle cycle so writes have landed
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= s;
		adr <= {idx, 2'b00}; dat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd = dat_o;
		e = err_o;
		if (n >= 20) begin
			chk(32'h0000_0000, 32'h0000_0001);
			complete_run();
		end
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'h1);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00, 4'hf);
		chk(rd, exp);
	endtask
	initial begin
		#200000;
		chk(32'h0000_0000, 32'h0000_0001);
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk(route_o, 32'h0000_0002);
		chk(p0_dig_iso_o, 32'h0000_0008);
		rdc(apc_pkg::IDX_CMP2_CONFIG, 32'h0000_0000);
		rdc(apc_pkg::IDX_OPAMP_MODE, 32'h0000_0000);
		rdc(apc_pkg::IDX_ADC_MODE, 32'h0000_0000);
		wr(apc_pkg::IDX_PORT0_ISO, 8'h0f);
		chk(p0_dig_iso_o, 32'h0000_000f);
		rdc(apc_pkg::IDX_PORT0_ISO, 32'h0000_0000);
		// Lane 0 not selected, so the write must be dropped
		bus(1'b1, apc_pkg::IDX_PORT0_ISO, 8'h00, 4'h2);
		chk(p0_dig_iso_o, 32'h0000_000f);
		wr(apc_pkg::IDX_CMP2_CONFIG, 8'h04);
		wr(apc_pkg::IDX_PORT0_ISO, 8'h01);
		chk(route_o, 32'h0000_0001);
		chk(p0_dig_iso_o, 32'h0000_0001);
		p0_lvl <= 6'h3f;
		repeat (4) @(posedge clk_i);
		rdc(apc_pkg::IDX_PORT0_DATA, 32'h0000_003b);
		wr(apc_pkg::IDX_PORT0_ISO, 8'h03);
		wr(apc_pkg::IDX_CMP2_CONFIG, 8'h00);
		chk(p0_dig_iso_o, 32'h0000_000b);
		chk(route_o, 32'h0000_0002);
		wr(apc_pkg::IDX_PORT4_ISO, 8'h55);
		chk(p4_dig_iso_o, 32'h0000_0055);
		p4_lvl <= 8'hff;
		repeat (4) @(posedge clk_i);
		rdc(apc_pkg::IDX_PORT4_DATA, 32'h0000_00aa);
		rdc(apc_pkg::IDX_PORT4_ISO, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			wr(apc_pkg::IDX_ADC_MODE, 8'h90 | 8'(c));
			chk(route_o.adc_pin_sel, (c < 7) ? (32'h1 << c) : 32'h0);
			chk(route_o.adc_sel_opamp, (c == 7));
			chk(route_o.adc_en, 32'h0000_0001);
		end
		wr(apc_pkg::IDX_ADC_MODE, 8'h82);
		chk(route_o.adc_pin_sel, 32'h0000_0000);
		wr(apc_pkg::IDX_ADC_MODE, 8'h00);
		wr(apc_pkg::IDX_OPAMP_MODE, 8'h01);
		chk(route_o[5:2], 32'h0000_000e);
		wr(apc_pkg::IDX_OPAMP_MODE, 8'h03);
		chk(route_o[5:2], 32'h0000_000d);
		rdc(apc_pkg::IDX_OPAMP_MODE, 32'h0000_0003);
		wr(apc_pkg::IDX_ADC_MODE, 8'h80);
		chk(route_o[5:2], 32'h0000_0001);
		wr(apc_pkg::IDX_OPAMP_MODE, 8'h00);
		chk(route_o[5:2], 32'h0000_0000);
		bus(1'b0, 8'h10, 8'h00, 4'hf);
		chk(e, 32'h0000_0001);
		complete_run();
	end
endmodule // testbench
`default_nettype wire
